// *** rtl/gmp_pkg.sv ***
// constants, types and register map of the green-mode pwm control core
package gmp_pkg;
  localparam int CLK_HZ      = 125_000_000;
  localparam int CLK_NS      = 8;
  localparam int F_NOM_HZ    = 65000;
  localparam int F_GREEN_HZ  = 22500;
  localparam int F_HOP_LO_HZ = 60800;
  localparam int F_HOP_HI_HZ = 69200;
  localparam logic [12:0] PER_NOM     = 13'(CLK_HZ / F_NOM_HZ);
  localparam logic [12:0] PER_GREEN   = 13'(CLK_HZ / F_GREEN_HZ);
  localparam logic [12:0] PER_HOP_MAX = 13'(CLK_HZ / F_HOP_LO_HZ);
  localparam logic [12:0] PER_HOP_MIN = 13'(CLK_HZ / F_HOP_HI_HZ);
  localparam logic [11:0] PER_SPAN    = 12'(PER_GREEN - PER_NOM);
  localparam int T_LEB_NS    = 360;
  localparam logic [12:0] LEB_CYC = 13'((T_LEB_NS + CLK_NS - 1) / CLK_NS);
  localparam int T_OVP_NS    = 30_000;
  localparam logic [23:0] OVP_CYC = 24'(T_OVP_NS / CLK_NS);
  localparam int T_OLP_NS    = 56_000_000;
  localparam int T_OCP_NS    = 56_000_000;
  localparam int T_OTP1S_NS  = 17_000_000;
  localparam int T_OTP1L_NS  = 51_000_000;
  localparam int T_OTP2_NS   = 100_000;
  localparam int T_SS_NS     = 4_000_000;
  localparam int T_HOP_NS    = 4_400_000;
  localparam int DUTY_MAX_PCT = 70;
  localparam logic [7:0]  DUTY_Q8    = 8'(DUTY_MAX_PCT * 256 / 100);
  localparam logic [7:0]  SAW_VALLEY = 8'he1;
  localparam logic [7:0]  SAW_STEP   = 8'h2d;
  localparam logic [7:0]  REF_TOP    = 8'hff;
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam int DB_OLP  = 0;
  localparam int DB_OCP  = 1;
  localparam int DB_OVP  = 2;
  localparam int DB_OTP1 = 3;
  localparam int DB_OTP2 = 4;
  localparam int DB_N    = 5;
  localparam int FLAG_W  = 13;

  typedef enum logic [1:0] {
    ST_START = 2'b00, ST_RUN = 2'b01, ST_AUTO = 2'b11, ST_LATCH = 2'b10
  } gmp_state_t;

  typedef struct packed {
    logic sup_on;   logic sup_off;  logic sup_rel;  logic sup_ovp;
    logic fb_n;     logic fb_g;     logic fb_zdc;   logic fb_olp;
    logic cs_lim;   logic cs_ocp;   logic cs_short;
    logic temp_lo1; logic temp_lo2;
  } gmp_flags_t;

  typedef struct packed {
    logic force_off;
    logic hop_en;
  } gmp_ctrl_t;

  localparam gmp_ctrl_t CTRL_RST = '{force_off: 1'b0, hop_en: 1'b1};
endpackage : gmp_pkg

// *** rtl/gmp_core.sv ***
// green-mode flyback pwm control core: timing, protection and gate drive
// Functional notes
// - no switching until supply reaches turn-on
// - heavy load switches at nominal frequency
// - frequency falls linearly below reduction threshold
// - green floor holds minimum frequency, deep green
// - below zero-duty threshold switching stops, burst
// - at heavy load, frequency sweeps between hop limits periodically
// - overload, overcurrent, short auto-restart; ovp, otp latch (here only the second otp threshold latches)
// - any fault stops switching, gate held low
// - auto fault clears at turn-off, restarts at turn-on
// - latch clears only below release level
// - current limit ends pulse for rest of cycle
// - sustained overcurrent past delay raises fault
// - sustained open-loop feedback past delay raises fault
// - supply overvoltage debounced before latching fault
// - first temperature threshold disables gate after debounce
// - first temperature debounce depends on load
// - second temperature threshold latches after debounce
// - second temperature debounce is short fixed
// - current limit threshold rises as sawtooth
// - sense ignored during turn-on blanking; the core blanks only the current-limit trip, not overcurrent or short
// - soft-start ramps current limit reference
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module gmp_core import gmp_pkg::*; #(
  parameter int OLP_CYC   = T_OLP_NS / CLK_NS,
  parameter int OCP_CYC   = T_OCP_NS / CLK_NS,
  parameter int OTP1S_CYC = T_OTP1S_NS / CLK_NS,
  parameter int OTP1L_CYC = T_OTP1L_NS / CLK_NS,
  parameter int OTP2_CYC  = T_OTP2_NS / CLK_NS,
  parameter int SS_CYC    = T_SS_NS / CLK_NS,
  parameter int HOP_CYC   = T_HOP_NS / CLK_NS
)(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire gmp_flags_t  flags_in,
  input  wire logic [7:0]  fb_frac,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             gate_drive,
  output logic      [7:0]  cl_ref,
  output logic             startup_only,
  output logic             deep_green
);
  localparam logic [23:0] SS_STEP  = 24'(SS_CYC / 256);
  localparam logic [23:0] HOP_STEP = 24'(HOP_CYC / (2 * (PER_HOP_MAX - PER_HOP_MIN)));

  function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  // flag synchronisers: first stage feeds only the second
  logic [FLAG_W-1:0] fl_vec;
  gmp_flags_t        fl;
  genvar g;
  generate
    for (g = 0; g < FLAG_W; g++) begin : g_sync
      logic s1;
      logic s2;
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
        end else begin
          s1 <= flags_in[g];
          s2 <= s1;
        end
      end
      assign fl_vec[g] = s2;
    end
  endgenerate
  assign fl = gmp_flags_t'(fl_vec);

  // feedback position code is quasi-static; a torn sample only nudges one period
  logic [7:0] frac1;
  logic [7:0] frac_s;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frac1  <= 8'h00;
      frac_s <= 8'h00;
    end else begin
      frac1  <= fb_frac;
      frac_s <= frac1;
    end
  end

  // debounce timers
  logic [DB_N-1:0] db_cond;
  logic [DB_N-1:0] db_done;
  logic [23:0]     db_lim [DB_N];
  assign db_cond = {fl.temp_lo2, fl.temp_lo1, fl.sup_ovp, fl.cs_ocp, fl.fb_olp};
  assign db_lim[DB_OLP]  = 24'(OLP_CYC);
  assign db_lim[DB_OCP]  = 24'(OCP_CYC);
  assign db_lim[DB_OVP]  = OVP_CYC;
  assign db_lim[DB_OTP1] = fl.fb_n ? 24'(OTP1S_CYC) : 24'(OTP1L_CYC);
  assign db_lim[DB_OTP2] = 24'(OTP2_CYC);
  generate
    for (g = 0; g < DB_N; g++) begin : g_db
      logic [23:0] cnt;
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          cnt <= 24'h000000;
        end else if (!db_cond[g]) begin
          cnt <= 24'h000000;
        end else if (cnt < db_lim[g]) begin
          cnt <= cnt + 24'h000001;
        end
      end
      assign db_done[g] = db_cond[g] && (cnt >= db_lim[g]);
    end
  endgenerate

  logic auto_now;
  logic latch_now;
  logic otp_hold;
  assign auto_now  = db_done[DB_OLP] | db_done[DB_OCP] | fl.cs_short;
  assign latch_now = db_done[DB_OVP] | db_done[DB_OTP2];
  assign otp_hold  = db_done[DB_OTP1];

  // protection state machine
  gmp_state_t state;
  gmp_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      ST_START: begin
        if (latch_now) next_state = ST_LATCH;
        else if (fl.sup_on) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (latch_now) next_state = ST_LATCH;
        else if (auto_now) next_state = ST_AUTO;
        else if (fl.sup_off) next_state = ST_START;
      end
      ST_AUTO: begin
        if (latch_now) next_state = ST_LATCH;
        else if (fl.sup_off) next_state = ST_START;
      end
      ST_LATCH: begin
        if (fl.sup_rel) next_state = ST_START;
      end
      default: next_state = ST_START;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) state <= ST_START;
    else         state <= next_state;
  end

  // fault cause kept until the next run entry; a new fault wins over the clear
  logic [5:0] cause;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cause <= 6'h00;
    end else if (next_state != state && next_state inside {ST_AUTO, ST_LATCH}) begin
      cause <= {fl.cs_short, db_done};
    end else if (next_state == ST_RUN && state != ST_RUN) begin
      cause <= 6'h00;
    end
  end

  // software control register
  gmp_ctrl_t ctrl;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)                        ctrl <= CTRL_RST;
    else if (wr && reg_hit(addr, ADDR_CTRL)) ctrl <= gmp_ctrl_t'(wdata[1:0]);
  end

  // frequency hopping sweep of the nominal period
  logic [12:0] hop_per;
  logic        hop_up;
  logic [23:0] hop_cnt;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hop_per <= PER_NOM;
      hop_up  <= 1'b1;
      hop_cnt <= 24'h000000;
    end else if (hop_cnt >= HOP_STEP - 24'h000001) begin
      hop_cnt <= 24'h000000;
      if (hop_up) begin
        if (hop_per >= PER_HOP_MAX) hop_up <= 1'b0;
        else hop_per <= hop_per + 13'h0001;
      end else begin
        if (hop_per <= PER_HOP_MIN) hop_up <= 1'b1;
        else hop_per <= hop_per - 13'h0001;
      end
    end else begin
      hop_cnt <= hop_cnt + 24'h000001;
    end
  end

  // period selection from load
  logic [12:0] next_period;
  logic [19:0] prod;
  assign prod = 20'(PER_SPAN) * 20'(8'hff - frac_s);
  always_comb begin
    if (fl.fb_n)      next_period = ctrl.hop_en ? hop_per : PER_NOM;
    else if (fl.fb_g) next_period = PER_NOM + 13'(prod >> 8);
    else              next_period = PER_GREEN;
  end

  logic [12:0] period;
  logic [12:0] cyc_cnt;
  logic [12:0] dmax;
  logic [20:0] dprod;
  assign dprod = 21'(period) * 21'(DUTY_Q8);
  assign dmax  = 13'(dprod >> 8);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      period  <= PER_NOM;
      cyc_cnt <= 13'h0000;
    end else if (state != ST_RUN) begin
      period  <= PER_NOM;
      cyc_cnt <= 13'h0000;
    end else if (cyc_cnt >= period - 13'h0001) begin
      period  <= next_period;
      cyc_cnt <= 13'h0000;
    end else begin
      cyc_cnt <= cyc_cnt + 13'h0001;
    end
  end

  // gate drive; current-limit trips are ignored inside the blanking window
  logic gate_ok;
  logic next_gate;
  assign gate_ok = state == ST_RUN && next_state == ST_RUN && fl.fb_zdc
                   && !otp_hold && !ctrl.force_off;
  always_comb begin
    if (!gate_ok)                                  next_gate = 1'b0;
    else if (cyc_cnt == 13'h0000)                  next_gate = 1'b1;
    else if (cyc_cnt >= dmax)                      next_gate = 1'b0;
    else if (cyc_cnt >= LEB_CYC && fl.cs_lim)      next_gate = 1'b0;
    else                                           next_gate = gate_drive;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gate_drive   <= 1'b0;
      startup_only <= 1'b1;
      deep_green   <= 1'b0;
    end else begin
      gate_drive   <= next_gate;
      startup_only <= next_state != ST_RUN;
      deep_green   <= !fl.fb_g;
    end
  end

  // sawtooth limit synchronised to cycle start
  logic [7:0] saw;
  logic [7:0] saw_cnt;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      saw     <= SAW_VALLEY;
      saw_cnt <= 8'h00;
    end else if (cyc_cnt == 13'h0000) begin
      saw     <= SAW_VALLEY;
      saw_cnt <= 8'h00;
    end else if (saw_cnt >= SAW_STEP - 8'h01) begin
      saw_cnt <= 8'h00;
      if (saw != REF_TOP) saw <= saw + 8'h01;
    end else begin
      saw_cnt <= saw_cnt + 8'h01;
    end
  end

  // soft-start ramp restarts on every run entry
  logic [7:0]  ss_level;
  logic [23:0] ss_cnt;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ss_level <= 8'h00;
      ss_cnt   <= 24'h000000;
    end else if (state != ST_RUN) begin
      ss_level <= 8'h00;
      ss_cnt   <= 24'h000000;
    end else if (ss_cnt >= SS_STEP - 24'h000001) begin
      ss_cnt <= 24'h000000;
      if (ss_level != REF_TOP) ss_level <= ss_level + 8'h01;
    end else begin
      ss_cnt <= ss_cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) cl_ref <= 8'h00;
    else         cl_ref <= (ss_level < saw) ? ss_level : saw;
  end

  // register read: data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h00000000;
    end else if (rd && reg_hit(addr, ADDR_CTRL)) begin
      rdata <= {30'h00000000, ctrl};
    end else if (rd && reg_hit(addr, ADDR_STATUS)) begin
      rdata <= {20'h00000, gate_drive, !fl.fb_zdc, deep_green, otp_hold, cause, state};
    end else begin
      rdata <= 32'h00000000;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_idle_off;
    state != ST_RUN |=> !gate_drive;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("gate on outside run");
  property p_nominal;
    (state == ST_RUN && cyc_cnt >= period - 13'h0001 && fl.fb_n && ctrl.hop_en)
      |=> period == $past(hop_per);
  endproperty
  a_nominal: assert property (p_nominal) else $error("heavy load period wrong");
  property p_burst;
    (cyc_cnt == 13'h0000 && !fl.fb_zdc) |=> !gate_drive;
  endproperty
  a_burst: assert property (p_burst) else $error("pulse in burst off");
  property p_auto_clear;
    (state == ST_AUTO && fl.sup_off && !latch_now) |=> state == ST_START && startup_only;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("auto fault not cleared");
  property p_latch_hold;
    (state == ST_LATCH && !fl.sup_rel) |=> state == ST_LATCH;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released early");
  property p_limit;
    (gate_drive && cyc_cnt >= LEB_CYC && fl.cs_lim) |=> !gate_drive;
  endproperty
  a_limit: assert property (p_limit) else $error("current limit ignored");
  property p_blank;
    (gate_drive && cyc_cnt < LEB_CYC && gate_ok) |=> gate_drive;
  endproperty
  a_blank: assert property (p_blank) else $error("pulse cut in blanking");
  property p_dmax;
    gate_drive |-> cyc_cnt <= dmax;
  endproperty
  a_dmax: assert property (p_dmax) else $error("duty beyond maximum");
  property p_ocp;
    (state == ST_RUN && db_done[DB_OCP] && !latch_now) |=> state == ST_AUTO ##1 !gate_drive;
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent not taken");
  property p_ovp;
    (state != ST_LATCH && fl.sup_ovp && db_done[DB_OVP]) |=> state == ST_LATCH;
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage not latched");
  property p_soft;
    state == ST_RUN |=> cl_ref <= $past(ss_level);
  endproperty
  a_soft: assert property (p_soft) else $error("limit above soft-start");

  c_run:   cover property (state == ST_START ##1 state == ST_RUN);
  c_auto:  cover property (state == ST_AUTO ##1 state == ST_START);
  c_latch: cover property (state == ST_RUN ##1 state == ST_LATCH);
  c_trip:  cover property (gate_drive && fl.cs_lim && cyc_cnt >= LEB_CYC);
endmodule : gmp_core

// *** bench/gmp_stage.sv ***
// power stage model: primary current ramp as seen by the sense comparator
`timescale 1ns/100ps
module gmp_stage (
  input  wire logic        clk_sys,
  input  wire logic        gate_drive,
  input  wire logic [12:0] trip_at,
  output logic             cs_lim
);
  logic [12:0] ramp;

  // current only builds while the switch conducts and collapses at turn-off,
  // so the flag lingers at most one cycle into the off time
  always_ff @(posedge clk_sys) begin
    ramp   <= gate_drive ? ramp + 13'h1 : 13'h0;
    cs_lim <= gate_drive && (ramp >= trip_at);
  end
endmodule : gmp_stage

// *** bench/gmp_core_tb.sv ***
// self-checking bench of the green-mode pwm control core
`timescale 1ns/100ps
module gmp_core_tb import gmp_pkg::*;;
  logic        clk_sys;
  logic        resetn;
  gmp_flags_t  fl;
  gmp_flags_t  fin;
  logic [7:0]  fb_frac;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        gate_drive;
  logic [7:0]  cl_ref;
  logic        startup_only;
  logic        deep_green;
  logic        cs_m;
  logic [12:0] trip_at;
  logic [31:0] d;
  logic [7:0]  c0;
  int          fails;
  int          tests_run;
  int          p;
  int          h;
  int          n;
  int          pmin;
  int          pmax;
  // shortened protection, soft-start and hop timers so every fault path fits in one run
  localparam int SH_OLP  = 200;
  localparam int SH_OCP  = 200;
  localparam int SH_OTP1S = 100;
  localparam int SH_OTP1L = 300;
  localparam int SH_OTP2 = 20;
  localparam int SH_SS   = 2560;
  localparam int SH_HOP  = 4980;

  always_comb begin
    fin        = fl;
    fin.cs_lim = fl.cs_lim | cs_m;
  end

  gmp_core #(.OLP_CYC(SH_OLP), .OCP_CYC(SH_OCP), .OTP1S_CYC(SH_OTP1S), .OTP1L_CYC(SH_OTP1L),
    .OTP2_CYC(SH_OTP2), .SS_CYC(SH_SS), .HOP_CYC(SH_HOP)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .flags_in(fin), .fb_frac(fb_frac),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .gate_drive(gate_drive), .cl_ref(cl_ref), .startup_only(startup_only),
    .deep_green(deep_green));

  gmp_stage stage (.clk_sys(clk_sys), .gate_drive(gate_drive), .trip_at(trip_at), .cs_lim(cs_m));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", what, e, g);
      fails++;
    end
  endtask : chk

  task rng(input string what, input int lo, input int hi, input int g);
    tests_run++;
    if (g < lo || g > hi) begin
      $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, g);
      fails++;
    end
  endtask : rng

  task wrr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask : wrr

  task rdr(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask : rdr

  // wait for gate level v, counting edges; a stuck gate ends the wait
  task wt(input logic v, output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (gate_drive !== v && c < 12000);
  endtask : wt

  task meas(output int per, output int hi);
    int c;
    wt(1'b0, c);
    wt(1'b1, c);
    wt(1'b0, hi);
    wt(1'b1, c);
    per = hi + c;
  endtask : meas

  task wait_so(input logic v, input int lim, output int c);
    c = 0;
    while (startup_only !== v && c < lim) begin
      @(posedge clk_sys);
      c++;
    end
  endtask : wait_so

  task fault(input int k, input logic [1:0] st, input int lo);
    int c;
    int g;
    @(posedge clk_sys);
    fl[k] <= 1'b1;
    wait_so(1'b1, lo + 4000, c);
    rng("fault delay", lo, lo + 12, c);
    rdr(ADDR_STATUS, d);
    chk("fault class", {30'h0, st}, {30'h0, d[1:0]});
    g = 0;
    repeat (500) begin
      @(posedge clk_sys);
      if (gate_drive !== 1'b0) g++;
    end
    chk("gate in fault", 32'h0, 32'(g));
    fl[k]      <= 1'b0;
    fl.sup_on  <= 1'b0;
    fl.sup_off <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rdr(ADDR_STATUS, d);
    chk("state at turn-off", {30'h0, (st == ST_AUTO) ? ST_START : ST_LATCH}, {30'h0, d[1:0]});
    fl.sup_rel <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rdr(ADDR_STATUS, d);
    chk("state at release", {30'h0, ST_START}, {30'h0, d[1:0]});
    fl.sup_rel <= 1'b0;
    fl.sup_off <= 1'b0;
    fl.sup_on  <= 1'b1;
    wait_so(1'b0, 20, c);
    chk("restart", 32'h0, {31'h0, startup_only});
  endtask : fault

  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    complete_run;
  end

  initial begin
    fails = 0;
    tests_run = 0;
    resetn = 1'b0;
    fl = '0;
    fb_frac = 8'hff;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    trip_at = 13'h1fff;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    rdr(ADDR_CTRL, d);
    chk("ctrl reset", 32'h1, d);
    rdr(4'h8, d);
    chk("unmapped read", 32'h0, d);
    wrr(ADDR_CTRL, 32'h0);
    fl.fb_n <= 1'b1;
    fl.fb_g <= 1'b1;
    fl.fb_zdc <= 1'b1;
    repeat (50) @(posedge clk_sys);
    chk("gate before turn-on", 32'h0, {31'h0, gate_drive});
    chk("start-up current", 32'h1, {31'h0, startup_only});
    fl.sup_on <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("gate before sync", 32'h0, {31'h0, gate_drive});
    wt(1'b1, n);
    rng("turn-on latency", 1, 4, n);
    c0 = cl_ref;
    rng("soft-start begin", 0, 8, int'(c0));
    repeat (2700) @(posedge clk_sys);
    meas(p, h);
    rng("nominal period", PER_NOM - 1, PER_NOM + 1, p);
    rng("max duty", (p * DUTY_Q8) / 256 - 2, (p * DUTY_Q8) / 256 + 1, h);
    wt(1'b1, n);
    repeat (2) @(posedge clk_sys);
    c0 = cl_ref;
    repeat (900) @(posedge clk_sys);
    rng("sawtooth valley", SAW_VALLEY - 1, SAW_VALLEY + 1, int'(c0));
    rng("sawtooth rise", int'(c0) + 15, 255, int'(cl_ref));
    trip_at = 13'h0;
    meas(p, h);
    rng("blanked pulse", 45, 50, h);
    trip_at = 13'h1fff;
    fl.fb_n <= 1'b0;
    for (int f = 0; f < 256; f += 128) begin
      fb_frac <= 8'(f);
      meas(p, h);
      meas(p, h);
      n = PER_NOM + (PER_SPAN * (255 - f)) / 255;
      rng("reduced period", n - 24, n + 24, p);
    end
    fl.fb_g <= 1'b0;
    meas(p, h);
    rng("green floor period", PER_GREEN - 2, PER_GREEN + 2, p);
    chk("deep green", 32'h1, {31'h0, deep_green});
    fl.fb_zdc <= 1'b0;
    repeat (8) @(posedge clk_sys);
    n = 0;
    repeat (6000) begin
      @(posedge clk_sys);
      if (gate_drive !== 1'b0) n++;
    end
    chk("burst off", 32'h0, 32'(n));
    fl.fb_zdc <= 1'b1;
    wt(1'b1, n);
    rng("burst resume", 1, PER_GREEN + 8, n);
    fl.fb_n <= 1'b1;
    fl.fb_g <= 1'b1;
    wrr(ADDR_CTRL, 32'h1);
    pmin = 9999;
    pmax = 0;
    repeat (5) begin
      meas(p, h);
      pmin = (p < pmin) ? p : pmin;
      pmax = (p > pmax) ? p : pmax;
    end
    rng("hop low", PER_HOP_MIN - 1, PER_HOP_MAX + 1, pmin);
    rng("hop high", PER_HOP_MIN - 1, PER_HOP_MAX + 1, pmax);
    rng("hop spread", 60, 300, pmax - pmin);
    wrr(ADDR_CTRL, 32'h3);
    rdr(ADDR_CTRL, d);
    chk("ctrl readback", 32'h3, d);
    n = 0;
    repeat (2500) begin
      @(posedge clk_sys);
      if (gate_drive !== 1'b0) n++;
    end
    chk("gate in software shutdown", 32'h0, 32'(n));
    wrr(ADDR_CTRL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      fl.fb_n <= (i == 0);
      fl.temp_lo1 <= 1'b1;
      n = 0;
      d = 32'h0;
      while (d[8] !== 1'b1 && n < 800) begin
        rdr(ADDR_STATUS, d);
        n += 2;
      end
      rng("first temp debounce", (i == 0) ? 100 : 300, (i == 0) ? 118 : 318, n);
      fl.temp_lo1 <= 1'b0;
      repeat (20) @(posedge clk_sys);
    end
    fl.fb_n <= 1'b1;
    fault(5, ST_AUTO, 200);
    fault(3, ST_AUTO, 200);
    fault(2, ST_AUTO, 0);
    fault(9, ST_LATCH, int'(OVP_CYC));
    fault(0, ST_LATCH, 20);
    complete_run;
  end
endmodule : gmp_core_tb
